// [verilog/acs_pkg.sv]
// Purpose: Shared constants, types and helpers of the ADC conversion sequencer.
// Assumes: The controller clock mclk runs at 125 MHz.
// Notes:   Least times round up to whole cycles, longest times round down.
`default_nettype none
package acs_pkg;
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CNT_W          = 24;
    localparam int SYNC_STAGES    = 2;

    // Times in their own unit, figures as printed.
    localparam int T_RESET_NS     = 50;
    localparam int T_RST_CONV_NS  = 25;
    localparam int T_CONV_LOW_NS  = 25;
    localparam int T_CONV_HIGH_NS = 25;
    localparam int T_BUSY_RISE_NS = 45;
    localparam int T_CYCLE_NS     = 5000;
    localparam int T_OS_SETUP_NS  = 20;
    localparam int T_OS_HOLD_NS   = 20;
    localparam int T_RD_LOW_NS    = 37;
    localparam int T_RD_HIGH_NS   = 15;
    localparam int T_STAGGER_MS_X10 = 5;
    localparam int T_WAKE_LOW_POWER_CONTROL_N_US = 100;
    localparam int T_WAKE_INT_MS  = 30;
    localparam int T_WAKE_EXT_MS  = 13;
    localparam int T_CONV_MAX_US  = 315;

    // Derived cycle counts.
    localparam int RESET_CYC     = (T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CONV_CYC  = (T_RST_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_LOW_CYC  = (T_CONV_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_HIGH_CYC = (T_CONV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_RISE_CYC = T_BUSY_RISE_NS / CLK_PERIOD_NS + SYNC_STAGES + 1;
    localparam int CYCLE_CYC     = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OS_SETUP_CYC  = (T_OS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OS_HOLD_CYC   = (T_OS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_LOW_CYC    = (T_RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_HIGH_CYC   = (T_RD_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAGGER_MAX_CYC = T_STAGGER_MS_X10 * 100_000 / CLK_PERIOD_NS;
    localparam int WAKE_LOW_POWER_CONTROL_N_CYC_DEF = T_WAKE_LOW_POWER_CONTROL_N_US * 1000 / CLK_PERIOD_NS;
    localparam int WAKE_INT_CYC_DEF  = T_WAKE_INT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int WAKE_EXT_CYC_DEF  = T_WAKE_EXT_MS * 1_000_000 / CLK_PERIOD_NS;
    localparam int BUSY_TMO_CYC_DEF  = 2 * T_CONV_MAX_US * 1000 / CLK_PERIOD_NS;

    localparam logic [1:0] PWR_NORMAL   = 2'h0;
    localparam logic [1:0] PWR_STANDBY  = 2'h1;
    localparam logic [1:0] PWR_SHUTDOWN = 2'h2;

    typedef logic [CNT_W-1:0] acs_cnt_t;

    typedef enum logic [3:0] {
        S_RST_HI  = 4'h0,
        S_RST_GAP = 4'h1,
        S_IDLE    = 4'h2,
        S_CONV_HI = 4'h3,
        S_BUSY_WT = 4'h4,
        S_CONV    = 4'h5,
        S_RD_LO   = 4'h6,
        S_RD_HI   = 4'h7,
        S_SLEEP   = 4'h8,
        S_WAKE    = 4'h9
    } acs_state_t;

    // Count register load for a phase lasting n cycles.
    function automatic acs_cnt_t acs_len(input int n);
        return acs_cnt_t'(n - 1);
    endfunction
endpackage
`default_nettype wire

// [verilog/acs_stream_if.sv]
// Purpose: Valid and ready word stream between sequencer and FIFO.
// Assumes: One word moves on each edge where valid and ready are both high.
// Notes:   None.
`timescale 1ns/100ps
`default_nettype none
interface acs_stream_if #(
    parameter int W = 16
) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [verilog/acs_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Multi-bit inputs are only sampled once they have settled.
// Notes:   The first stage feeds the second stage and nothing else.
`timescale 1ns/100ps
`default_nettype none
module acs_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule
`default_nettype wire

// [verilog/acs_fifo.sv]
// Purpose: Result FIFO between the read sequencer and the user.
// Assumes: DEPTH is a power of two, at least two.
// Notes:   Full and empty come from pointers with one extra wrap bit.
`timescale 1ns/100ps
`default_nettype none
module acs_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 8
) (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    acs_stream_if.snk   wr,
    acs_stream_if.src   rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    logic         full;
    logic         empty;

    assign full     = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty    = (wp == rp);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem[rp[AW-1:0]];

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wp <= '0;
        end else if (wr.valid && !full) begin
            wp <= wp + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rp <= '0;
        end else if (rd.ready && !empty) begin
            rp <= rp + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (wr.valid && !full) begin
            mem[wp[AW-1:0]] <= wr.data;
        end
    end
endmodule
`default_nettype wire

// [verilog/acs_adc_sequencer.sv]
// Purpose: Host-side sequencer that starts conversions on an eight-channel
//          simultaneous-sampling ADC, waits on its busy flag and reads results.
// Assumes: Parallel read after conversion; the device pins settle within the
//          printed limits; user inputs are on mclk.
// Notes:   Results enter a FIFO; a full FIFO stalls the read strobe.
// Contract
// - Each conversion-start pin stays low and high at least 25 ns.
// - The second start pin rises at most 0.5 ms after the first.
// - Reads during conversion end 25 ns before busy falls.
// - Chip select may fall as soon as busy has fallen.
// - Full conversion-and-read cycles repeat at most once every 5 us.
// - Parallel reads after conversion at low supply need about 5 us per cycle.
// - Serial reads after conversion on both outputs need up to 10.1 or 11.5 us.
// - Wait 100 us after leaving standby before a conversion start.
// - Wait 30 ms internal or 13 ms external reference after shutdown.
// - The device reset pulse is high for at least 50 ns.
// - Wait at least 25 ns after reset falls before conversion start.
`timescale 1ns/100ps
`default_nettype none
module acs_adc_sequencer
    import acs_pkg::*;
#(
    parameter int DATA_W        = 16,
    parameter int NUM_WORDS     = 8,
    parameter int FIFO_DEPTH    = 8,
    parameter int STAGGER_CYC   = 0,
    parameter int CYCLE_MIN_CYC = CYCLE_CYC,
    parameter int WAKE_LOW_POWER_CONTROL_N_CYC = WAKE_LOW_POWER_CONTROL_N_CYC_DEF,
    parameter int WAKE_INT_CYC  = WAKE_INT_CYC_DEF,
    parameter int WAKE_EXT_CYC  = WAKE_EXT_CYC_DEF,
    parameter int BUSY_TMO_CYC  = BUSY_TMO_CYC_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              start_req,
    input  wire logic              reset_req,
    input  wire logic [1:0]        power_mode,
    input  wire logic              ext_ref,
    input  wire logic [2:0]        os_ratio,
    output logic                   start_ready,
    output logic                   conv_active,
    output logic                   timeout_err,
    output logic                   out_valid,
    input  wire logic              out_ready,
    output logic [DATA_W-1:0]      out_data,
    input  wire logic              dev_busy,
    input  wire logic [DATA_W-1:0] dev_db,
    output logic                   conv_start_first_group,
    output logic                   conv_start_second_group,
    output logic                   dev_reset,
    output logic                   low_power_control_n,
    output logic                   shutdown_sel,
    output logic [2:0]             oversampling_ratio_select,
    output logic                   cs_n,
    output logic                   rd_n
);
    localparam int WORD_W = $clog2(NUM_WORDS);

    acs_state_t        state;
    acs_state_t        next_state;
    acs_cnt_t          cnt;
    acs_cnt_t          next_cnt;
    acs_cnt_t          gap_cnt;
    logic [WORD_W-1:0] word;
    logic [WORD_W-1:0] next_word;
    logic [3:0]        os_cnt;
    logic              sleep_deep;
    logic              sleep_ext;
    logic              busy_s;
    logic [DATA_W-1:0] db_s;
    logic              start_take;
    logic              tmo_hit;
    logic              last_word;

    acs_stream_if #(.W(DATA_W)) wr_if ();
    acs_stream_if #(.W(DATA_W)) rd_if ();

    acs_sync #(.W(1)) u_busy_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (dev_busy),
        .q     (busy_s)
    );

    acs_sync #(.W(DATA_W)) u_db_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .d     (dev_db),
        .q     (db_s)
    );

    acs_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk  (mclk),
        .rst_b (rst_b),
        .wr    (wr_if.snk),
        .rd    (rd_if.src)
    );

    assign out_valid   = rd_if.valid;
    assign out_data    = rd_if.data;
    assign rd_if.ready = out_ready;

    // A word is offered once the strobe has been low long enough for the
    // bus to settle and pass the synchroniser; a full FIFO keeps it low.
    assign wr_if.valid = (state == S_RD_LO) && (cnt == '0);
    assign wr_if.data  = db_s;
    assign last_word   = (word == WORD_W'(NUM_WORDS - 1));

    // Oversampling pins and cycle spacing must both have settled.
    assign start_ready = (state == S_IDLE) && (power_mode == PWR_NORMAL) && !reset_req
                         && (gap_cnt == '0) && (os_cnt == 4'h0)
                         && (os_ratio == oversampling_ratio_select);
    assign start_take  = start_req && start_ready;
    assign tmo_hit     = (cnt == '0) && ((state == S_BUSY_WT) || (state == S_CONV));

    always_comb begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - acs_len(2) : cnt;
        next_word  = word;
        case (state)
            S_RST_HI: begin
                if (cnt == '0) begin
                    next_state = S_RST_GAP;
                    next_cnt   = acs_len(RST_CONV_CYC);
                end
            end
            S_RST_GAP: begin
                if (cnt == '0) begin
                    next_state = S_IDLE;
                end
            end
            S_IDLE: begin
                if (power_mode != PWR_NORMAL) begin
                    next_state = S_SLEEP;
                end else if (reset_req) begin
                    next_state = S_RST_HI;
                    next_cnt   = acs_len(RESET_CYC);
                end else if (start_take) begin
                    next_state = S_CONV_HI;
                    next_cnt   = acs_len(STAGGER_CYC + CONV_HIGH_CYC);
                end
            end
            S_CONV_HI: begin
                if (cnt == '0) begin
                    next_state = S_BUSY_WT;
                    next_cnt   = acs_len(BUSY_RISE_CYC);
                end
            end
            S_BUSY_WT: begin
                if (busy_s) begin
                    next_state = S_CONV;
                    next_cnt   = acs_len(BUSY_TMO_CYC);
                end else if (cnt == '0) begin
                    next_state = S_IDLE;
                end
            end
            S_CONV: begin
                // Reading waits for busy itself, so every oversampling ratio
                // is served without a table of conversion times.
                if (!busy_s) begin
                    next_state = S_RD_LO;
                    next_cnt   = acs_len(RD_LOW_CYC + SYNC_STAGES);
                    next_word  = '0;
                end else if (cnt == '0) begin
                    next_state = S_IDLE;
                end
            end
            S_RD_LO: begin
                if ((cnt == '0) && wr_if.ready) begin
                    next_state = S_RD_HI;
                    next_cnt   = acs_len(RD_HIGH_CYC);
                end
            end
            S_RD_HI: begin
                if (cnt == '0) begin
                    if (last_word) begin
                        next_state = S_IDLE;
                    end else begin
                        next_state = S_RD_LO;
                        next_cnt   = acs_len(RD_LOW_CYC + SYNC_STAGES);
                        next_word  = word + 1'b1;
                    end
                end
            end
            S_SLEEP: begin
                if (power_mode == PWR_NORMAL) begin
                    next_state = S_WAKE;
                    if (!sleep_deep) begin
                        next_cnt = acs_len(WAKE_LOW_POWER_CONTROL_N_CYC);
                    end else if (sleep_ext) begin
                        next_cnt = acs_len(WAKE_EXT_CYC);
                    end else begin
                        next_cnt = acs_len(WAKE_INT_CYC);
                    end
                end
            end
            S_WAKE: begin
                if (cnt == '0) begin
                    next_state = S_IDLE;
                end
            end
            default: begin
                next_state = S_RST_HI;
                next_cnt   = acs_len(RESET_CYC);
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_RST_HI;
            cnt   <= acs_len(RESET_CYC);
            word  <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            word  <= next_word;
        end
    end

    // Pins follow the next state so they change on the same edge as the state.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dev_reset               <= 1'b1;
            conv_start_first_group  <= 1'b0;
            conv_start_second_group <= 1'b0;
            cs_n                    <= 1'b1;
            rd_n                    <= 1'b1;
            low_power_control_n     <= 1'b1;
            conv_active             <= 1'b0;
        end else begin
            dev_reset               <= (next_state == S_RST_HI);
            conv_start_first_group  <= (next_state == S_CONV_HI);
            conv_start_second_group <= (next_state == S_CONV_HI)
                                       && (next_cnt < acs_cnt_t'(CONV_HIGH_CYC));
            cs_n                    <= !((next_state == S_RD_LO) || (next_state == S_RD_HI));
            rd_n                    <= (next_state != S_RD_LO);
            low_power_control_n     <= (next_state != S_SLEEP);
            conv_active             <= (next_state == S_CONV_HI) || (next_state == S_BUSY_WT)
                                       || (next_state == S_CONV);
        end
    end

    // Depth and reference of a sleep are caught on entry and kept until the
    // wake time has been chosen, so the pin does not move during low power.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sleep_deep   <= 1'b0;
            sleep_ext    <= 1'b0;
            shutdown_sel <= 1'b0;
        end else if ((state == S_IDLE) && (next_state == S_SLEEP)) begin
            sleep_deep   <= (power_mode == PWR_SHUTDOWN);
            sleep_ext    <= ext_ref;
            shutdown_sel <= (power_mode == PWR_SHUTDOWN);
        end
    end

    // The cycle spacing runs from one start to the next, covering conversion
    // and read; longer serial cycles can be set through the parameter.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt <= '0;
        end else if (start_take) begin
            gap_cnt <= acs_len(CYCLE_MIN_CYC);
        end else if (gap_cnt != '0) begin
            gap_cnt <= gap_cnt - acs_len(2);
        end
    end

    // Oversampling pins change only while idle, after busy has fallen unless a stuck-busy timeout ended the conversion,
    // and a start waits for the setup time after any change.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oversampling_ratio_select <= 3'h0;
            os_cnt                    <= 4'h0;
        end else if ((state == S_IDLE) && (os_ratio != oversampling_ratio_select)) begin
            oversampling_ratio_select <= os_ratio;
            os_cnt                    <= 4'(OS_SETUP_CYC);
        end else if (os_cnt != 4'h0) begin
            os_cnt <= os_cnt - 4'h1;
        end
    end

    // A missing or stuck busy is reported until the next accepted start.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timeout_err <= 1'b0;
        end else if (tmo_hit && !(state == S_BUSY_WT && busy_s)
                     && !(state == S_CONV && !busy_s)) begin
            timeout_err <= 1'b1;
        end else if (start_take) begin
            timeout_err <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [verification/acs_adc_sequencer_checker.sv]
// Purpose: Timing checks on the sequencer's device-side pins.
// Assumes: Both start pins rise together, as with no stagger.
// Notes:   Long gaps use saturating counters, because repetition counts must stay small.
`timescale 1ns/100ps
`default_nettype none
module acs_adc_sequencer_checker #(
    parameter int CYCLE_MIN_CYC = 625,
    parameter int WAKE_LOW_POWER_CONTROL_N_CYC = 12500,
    parameter int WAKE_INT_CYC  = 3750000,
    parameter int WAKE_EXT_CYC  = 1625000
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ext_ref,
    input wire logic dev_busy,
    input wire logic conv_start_first_group,
    input wire logic conv_start_second_group,
    input wire logic dev_reset,
    input wire logic low_power_control_n,
    input wire logic shutdown_sel,
    input wire logic cs_n
);
    logic [23:0] cyc_cnt;
    logic [23:0] wake_cnt;
    logic [23:0] wake_need;
    logic [3:0]  rst_cnt;

    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    assign wake_need = !shutdown_sel ? 24'(WAKE_LOW_POWER_CONTROL_N_CYC) :
                       ext_ref ? 24'(WAKE_EXT_CYC) : 24'(WAKE_INT_CYC);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cyc_cnt <= '1;
        end else if ($rose(conv_start_first_group)) begin
            cyc_cnt <= 24'h1;
        end else if (cyc_cnt != '1) begin
            cyc_cnt <= cyc_cnt + 24'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wake_cnt <= '1;
        end else if ($rose(low_power_control_n)) begin
            wake_cnt <= 24'h1;
        end else if (wake_cnt != '1) begin
            wake_cnt <= wake_cnt + 24'h1;
        end
    end

    // The pin is already high during reset, so the count starts as a full pulse.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_cnt <= 4'h7;
        end else if (!dev_reset) begin
            rst_cnt <= 4'h0;
        end else if (rst_cnt != 4'hf) begin
            rst_cnt <= rst_cnt + 4'h1;
        end
    end

    AST_CONV_HIGH_MIN: assert property (
        $rose(conv_start_first_group) |-> conv_start_first_group[*4])
        else $error("start pin high pulse too short");
    AST_CONV_LOW_MIN: assert property (
        $fell(conv_start_second_group) |-> !conv_start_second_group[*4])
        else $error("start pin low pulse too short");
    AST_GROUP_SKEW: assert property (
        $rose(conv_start_first_group) |-> conv_start_second_group)
        else $error("second start pin late");
    AST_RESET_WIDTH: assert property (
        $fell(dev_reset) |-> rst_cnt >= 4'h7)
        else $error("device reset pulse too short");
    AST_RESET_TO_START: assert property (
        $fell(dev_reset) |-> (!conv_start_first_group && !conv_start_second_group)[*4])
        else $error("start too soon after device reset");
    AST_CS_AFTER_BUSY: assert property (
        $fell(cs_n) |-> !dev_busy && !$past(dev_busy))
        else $error("chip select fell while busy");
    AST_NO_READ_IN_BUSY: assert property (
        !cs_n |-> !dev_busy)
        else $error("read cycle overlaps busy");
    AST_CYCLE_GAP: assert property (
        $rose(conv_start_first_group) |-> cyc_cnt >= CYCLE_MIN_CYC)
        else $error("conversions closer than the cycle time");
    AST_WAKE_GAP: assert property (
        $rose(conv_start_first_group) |-> wake_cnt >= wake_need)
        else $error("start before wake-up time");
endmodule

bind acs_adc_sequencer acs_adc_sequencer_checker #(
    .CYCLE_MIN_CYC(CYCLE_MIN_CYC),
    .WAKE_LOW_POWER_CONTROL_N_CYC(WAKE_LOW_POWER_CONTROL_N_CYC),
    .WAKE_INT_CYC (WAKE_INT_CYC),
    .WAKE_EXT_CYC (WAKE_EXT_CYC)
) u_checker (
    .mclk,
    .rst_b,
    .ext_ref,
    .dev_busy,
    .conv_start_first_group,
    .conv_start_second_group,
    .dev_reset,
    .low_power_control_n,
    .shutdown_sel,
    .cs_n
);
`default_nettype wire

// [verification/acs_adc_model.sv]
// Purpose: Behavioural model of the eight-channel converter's pins.
// Assumes: Parallel reads after conversion; start pins rise together.
// Notes:   Conversion time is scaled down; mute silences busy for timeout tests.
`timescale 1ns/100ps
`default_nettype none
module acs_adc_model #(
    parameter int BASE_NS = 160
) (
    input  wire logic       conv_start_first_group,
    input  wire logic [2:0] oversampling_ratio_select,
    input  wire logic       rd_n,
    input  wire logic       mute,
    input  wire logic       slow,
    output logic            dev_busy,
    output logic [15:0]     dev_db
);
    logic [7:0] conv_idx = 8'h00;
    logic [7:0] cur      = 8'h00;
    logic [2:0] word_idx = 3'h0;

    initial begin
        dev_busy = 1'b0;
        dev_db = 16'h0000;
    end

    always @(posedge conv_start_first_group) begin
        cur = conv_idx;
        conv_idx = conv_idx + 8'h01;
        word_idx = 3'h0;
        if (!mute) begin
            // Off the clock edge, so the synchroniser never races the pin.
            #(slow ? 42 : 10) dev_busy = 1'b1;
            #(BASE_NS << oversampling_ratio_select) dev_busy = 1'b0;
        end
    end

    // The bus carries junk until access time, so an early sample shows up as a miscompare.
    always @(negedge rd_n) begin
        dev_db = ~dev_db;
        #37 dev_db = 16'h5a00 ^ {cur, 5'h00, word_idx};
        word_idx = word_idx + 3'h1;
    end

    always @(posedge rd_n) begin
        #6 dev_db = ~dev_db;
    end
endmodule
`default_nettype wire

// [verification/test_adc_conversion_sequencer.sv]
// Purpose: Self-checking bench for the conversion sequencer and a device model.
// Assumes: Scaled cycle, wake and timeout counts; no start stagger.
// Notes:   Expected words are queued at each unmuted start and compared when popped.
`timescale 1ns/100ps
`default_nettype none
module test_adc_conversion_sequencer;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        start_req = 1'b0;
    logic        reset_req = 1'b0;
    logic [1:0]  power_mode = 2'h0;
    logic        ext_ref = 1'b0;
    logic [2:0]  os_ratio = 3'h0;
    logic        out_ready = 1'b0;
    logic        mute = 1'b0;
    logic        slow = 1'b0;
    logic        hold_off = 1'b1;
    logic        start_ready, conv_active, timeout_err, out_valid, dev_busy;
    logic [15:0] out_data, dev_db;
    logic        conv_start_first_group, conv_start_second_group, dev_reset;
    logic        low_power_control_n, shutdown_sel, cs_n, rd_n;
    logic [2:0]  oversampling_ratio_select;
    int          mismatches = 0;
    int          total_checks = 0;
    int          conv = 0;
    logic [15:0] exp_q[$];

    acs_adc_sequencer #(.CYCLE_MIN_CYC(50), .WAKE_LOW_POWER_CONTROL_N_CYC(20), .WAKE_INT_CYC(30),
        .WAKE_EXT_CYC(13), .BUSY_TMO_CYC(2000)) dut (.mclk, .rst_b, .start_req,
        .reset_req, .power_mode, .ext_ref, .os_ratio, .start_ready, .conv_active,
        .timeout_err, .out_valid, .out_ready, .out_data, .dev_busy, .dev_db,
        .conv_start_first_group, .conv_start_second_group, .dev_reset,
        .low_power_control_n, .shutdown_sel, .oversampling_ratio_select, .cs_n, .rd_n);

    acs_adc_model u_dev (.conv_start_first_group, .oversampling_ratio_select, .rd_n,
        .mute, .slow, .dev_busy, .dev_db);

    initial forever #4 mclk = ~mclk;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (start_ready !== 1'b1 && n < 3000);
        if (n >= 3000) check("start_ready", 16'(start_ready), 16'h1);
    endtask

    task automatic do_conv(input logic [2:0] os, input logic quiet);
        os_ratio <= os;
        mute <= quiet;
        slow <= 1'($urandom % 2);
        @(posedge mclk);
        wait_ready();
        for (int k = 0; k < 8; k++) if (!quiet) exp_q.push_back(16'h5a00 ^ {conv[7:0], 5'h00, k[2:0]});
        conv++;
        start_req <= 1'b1;
        @(posedge mclk);
        start_req <= 1'b0;
        @(posedge mclk);
        check("start_ready", 16'(start_ready), 16'h0);
        check("conv_active", 16'(conv_active), 16'h1);
        check("os_pins", 16'(oversampling_ratio_select), 16'(os));
        check("cs_n", 16'(cs_n), 16'h1);
    endtask

    // Random back-pressure; held off for the first two starts so the first conversion fills the FIFO.
    always @(posedge mclk) out_ready <= !hold_off && ($urandom % 4 != 0);

    always @(posedge mclk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            if (exp_q.size() == 0) check("out_valid", 16'h1, 16'h0);
            else check("out_data", out_data, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(83831));
        repeat (10) @(posedge mclk);
        rst_b <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            if (i == 2) hold_off <= 1'b0;
            do_conv(3'(i), 1'b0);
        end
        do_conv(3'h0, 1'b1);
        for (int n = 0; n < 40 && timeout_err !== 1'b1; n++) @(posedge mclk);
        check("timeout_err", 16'(timeout_err), 16'h1);
        do_conv(3'h1, 1'b0);
        check("timeout_err", 16'(timeout_err), 16'h0);
        for (int i = 0; i < 3; i++) begin
            wait_ready();
            ext_ref <= (i == 2);
            power_mode <= (i == 0) ? 2'h1 : 2'h2;
            repeat (3) @(posedge mclk);
            check("low_power_control_n", 16'(low_power_control_n), 16'h0);
            check("shutdown_sel", 16'(shutdown_sel), (i == 0) ? 16'h0 : 16'h1);
            power_mode <= 2'h0;
            repeat (3) @(posedge mclk);
            check("start_ready", 16'(start_ready), 16'h0);
            check("low_power_control_n", 16'(low_power_control_n), 16'h1);
            do_conv(3'h0, 1'b0);
        end
        wait_ready();
        reset_req <= 1'b1;
        @(posedge mclk);
        reset_req <= 1'b0;
        repeat (2) @(posedge mclk);
        check("dev_reset", 16'(dev_reset), 16'h1);
        do_conv(3'($urandom % 7), 1'b0);
        for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge mclk);
        check("words_left", 16'(exp_q.size()), 16'h0);
        complete_run();
    end

    // The tests need some four thousand cycles; this allows about six times that.
    initial begin
        #200_000;
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
